/* core/host_parallel_port_handshake.sv */
// host parallel port handshake: strobe combine, ready and data bus
// assumes an internal transfer controller and write buffer on clk
//
// Functional notes
// - access strobe low only when selected and the data strobes differ.
// - word or first half-word data reads fetch, ready high until loaded.
// - data-register writes hold ready high while the write buffer is full.
// - control, read/write and 16-bit half-word select are taken per access.
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_parallel_port_handshake #(
  parameter int DATA_W = 32
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              sixteenBitHostMode,
  input  wire logic              hostChipSelect,
  input  wire logic              hostDataStrobeOne,
  input  wire logic              hostDataStrobeTwo,
  input  wire logic              hostAddressStrobeN,
  input  wire logic [1:0]        hostAccessControl,
  input  wire logic              hostReadWriteSelect,
  input  wire logic              halfwordSelect,
  input  wire logic [DATA_W-1:0] hostDataIn,
  output logic      [DATA_W-1:0] hostDataOut,
  output logic                   hostDataOe,
  output logic                   hostReady_n,
  output logic                   fetchRequest,
  input  wire logic              fetchLoaded,
  input  wire logic [DATA_W-1:0] fetchData,
  input  wire logic              writeBufferFull,
  output logic                   writeStrobe,
  output logic      [DATA_W-1:0] writeData,
  output host_port_pkg::select_type accessSelect
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 6 + 2 + DATA_W;
  logic [SYNC_W-1:0] syncBus;
  logic              csS, ds1S, ds2S, asS, rwS, hwS;
  logic [1:0]        cntlS;
  logic [DATA_W-1:0] dataS;

  host_pin_sync #(.WIDTH(SYNC_W)) pinSync (
    .clk     (clk),
    .reset   (reset),
    .pinIn   ({hostChipSelect, hostDataStrobeOne, hostDataStrobeTwo,
               hostAddressStrobeN, hostReadWriteSelect, halfwordSelect,
               hostAccessControl, hostDataIn}),
    .syncOut (syncBus)
  );
  assign {csS, ds1S, ds2S, asS, rwS, hwS, cntlS, dataS} = syncBus;

  // ----------------------------------------
  // strobe combine and edges
  // ----------------------------------------
  function automatic logic strobe_n(input logic cs, input logic a,
                                    input logic b);
    strobe_n = (~(a ^ b)) | cs;
  endfunction

  logic hostAccessStrobe_n;
  logic strobePrev;
  logic strobeFall, strobeRise;
  assign hostAccessStrobe_n = strobe_n(csS, ds1S, ds2S);
  assign strobeFall = strobePrev & ~hostAccessStrobe_n;
  assign strobeRise = ~strobePrev & hostAccessStrobe_n;

  // ----------------------------------------
  // access state machine
  // ----------------------------------------
  typedef enum logic [3:0] {
    IDLE  = 4'h1,
    FETCH = 4'h2,
    READY = 4'h4,
    WBUSY = 4'h8
  } state_type;

  state_type                 state, next_state;
  logic                      next_strobePrev;
  logic                      secondHalf, next_secondHalf;
  logic                      fetchPending, next_fetchPending;
  logic [DATA_W-1:0]         next_hostDataOut;
  logic                      next_hostDataOe;
  logic                      next_fetchRequest;
  logic                      next_writeStrobe;
  logic [DATA_W-1:0]         next_writeData;
  host_port_pkg::select_type next_accessSelect;
  host_port_pkg::select_type sel;
  logic                      isData;

  always_comb begin
    sel.accessControl   = cntlS;
    sel.readWriteSelect = rwS;
    sel.halfwordSelect  = sixteenBitHostMode ? hwS : 1'h0;
    isData              = (cntlS == `HP_CNTL_DATA);
    next_state        = state;
    next_strobePrev   = hostAccessStrobe_n;
    next_secondHalf   = secondHalf;
    next_hostDataOut  = hostDataOut;
    next_hostDataOe   = hostDataOe & ~strobeRise;
    next_fetchRequest = 1'h0;
    next_writeStrobe  = 1'h0;
    next_writeData    = writeData;
    next_accessSelect = accessSelect;
    case (state)
      IDLE: begin
        if (strobeFall) begin
          next_accessSelect = sel;
          if (sel.readWriteSelect) begin
            next_hostDataOe = 1'h1;
            if (isData && !secondHalf) begin
              next_fetchRequest = 1'h1;
              next_state        = FETCH;
            end else begin
              next_state = READY;
            end
          end else if (isData && writeBufferFull) begin
            next_state = WBUSY;
          end else begin
            next_state = READY;
          end
        end
      end
      FETCH: begin
        if (fetchLoaded) begin
          next_hostDataOut = fetchData;
          next_state       = READY;
        end
      end
      WBUSY: begin
        if (!writeBufferFull) begin
          next_state = READY;
        end
      end
      READY: begin
        // the host ends the access only after ready
        if (strobeRise) begin
          next_state = IDLE;
          if (!accessSelect.readWriteSelect) begin
            next_writeStrobe = 1'h1;
            next_writeData   = dataS;
          end
          if (sixteenBitHostMode &&
              accessSelect.accessControl == `HP_CNTL_DATA) begin
            next_secondHalf = ~secondHalf;
          end else begin
            next_secondHalf = 1'h0;
          end
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
    // fetch outstanding, watched by the ready check
    next_fetchPending = (fetchPending & ~fetchLoaded) | next_fetchRequest;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state        <= IDLE;
      strobePrev   <= 1'h1;
      secondHalf   <= 1'h0;
      fetchPending <= 1'h0;
      hostDataOut  <= '0;
      hostDataOe   <= 1'h0;
      fetchRequest <= 1'h0;
      writeStrobe  <= 1'h0;
      writeData    <= '0;
      accessSelect <= '0;
    end else begin
      state        <= next_state;
      strobePrev   <= next_strobePrev;
      secondHalf   <= next_secondHalf;
      fetchPending <= next_fetchPending;
      hostDataOut  <= next_hostDataOut;
      hostDataOe   <= next_hostDataOe;
      fetchRequest <= next_fetchRequest;
      writeStrobe  <= next_writeStrobe;
      writeData    <= next_writeData;
      accessSelect <= next_accessSelect;
    end
  end

  // ready low only when the access may complete
  assign hostReady_n = ~(state == READY);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_fetch_holds_ready: assert property (@(posedge clk) disable iff (reset)
    fetchPending |-> hostReady_n)
    else $error("ready asserted before read data loaded");
  a_fetch_on_read: assert property (@(posedge clk) disable iff (reset)
    fetchRequest |-> accessSelect.readWriteSelect &&
      accessSelect.accessControl == `HP_CNTL_DATA)
    else $error("fetch issued for a non data read");
  a_full_blocks_ready: assert property (@(posedge clk) disable iff (reset)
    (state == WBUSY && writeBufferFull) |=> hostReady_n)
    else $error("ready asserted with write buffer full");
  a_loaded_gives_ready: assert property (@(posedge clk) disable iff (reset)
    (state == FETCH && fetchLoaded) |=> !hostReady_n)
    else $error("ready not returned after data load");
  a_space_gives_ready: assert property (@(posedge clk) disable iff (reset)
    (state == WBUSY && !writeBufferFull) |=> !hostReady_n)
    else $error("ready not returned after buffer space");
  a_strobe_combine: assert property (@(posedge clk) disable iff (reset)
    (!csS && (ds1S != ds2S)) |-> !hostAccessStrobe_n)
    else $error("access strobe not active while selected");
  a_select_sampled: assert property (@(posedge clk) disable iff (reset)
    (state == IDLE && strobeFall) |=>
      accessSelect.readWriteSelect == $past(rwS))
    else $error("select group not sampled at strobe fall");
  a_write_done: assert property (@(posedge clk) disable iff (reset)
    (state == READY && strobeRise && !accessSelect.readWriteSelect)
      |=> writeStrobe ##1 !writeStrobe)
    else $error("write strobe not one pulse");
endmodule

/* core/host_pin_sync.sv */
// two-flop synchroniser for host pins
// assumes asynchronous pin inputs, single clk domain
`timescale 1ns/1ps
module host_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1  <= '1;
      syncOut <= '1;
    end else begin
      stage1  <= pinIn;
      syncOut <= stage1;
    end
  end
endmodule

/* core/host_port_cfg.svh */
// constants for the host parallel port handshake
// assumes a 25 MHz core clock
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define HP_CLK_PERIOD_PS  40000
`define HP_MIN_LOW_PS     12500
`define HP_MIN_LOW_CLKS   4
`define HP_MIN_HIGH_CLKS  4
`define HP_CNTL_DATA      2'h3
`define HP_CNT_W          4
`endif

/* core/host_port_pkg.sv */
// types for the host parallel port handshake
// assumes host_port_cfg.svh beside it
package host_port_pkg;
  typedef struct packed {
    logic [1:0] accessControl;
    logic       readWriteSelect;
    logic       halfwordSelect;
  } select_type;
endpackage

/* tb/host_model.sv */
// host processor model driving the port pins
// assumes the port samples its pins on rising clk
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  input  wire logic        hostReady_n,
  input  wire logic [31:0] hostDataOut,
  output logic             hostChipSelect = 1'b1,
  output logic             hostDataStrobeOne = 1'b1,
  output logic             hostDataStrobeTwo = 1'b1,
  output logic             hostAddressStrobeN = 1'b1,
  output logic [1:0]       hostAccessControl = 2'h0,
  output logic             hostReadWriteSelect = 1'b0,
  output logic             halfwordSelect = 1'b0,
  output logic [31:0]      hostDataIn = 32'h0
);
  logic useTwo = 1'b0;
  // ----------------------------------------
  // one access, strobe held until ready
  // ----------------------------------------
  task automatic access(input logic [1:0] c, input logic r, h,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    hostAccessControl <= c;
    hostReadWriteSelect <= r;
    halfwordSelect <= h;
    hostDataIn <= d;
    @(posedge clk);
    hostChipSelect <= 1'b0;
    if (useTwo) begin
      hostDataStrobeTwo <= 1'b0;
    end else begin
      hostDataStrobeOne <= 1'b0;
    end
    hostAddressStrobeN <= 1'b0;
    @(posedge clk);
    hostAddressStrobeN <= 1'b1;
    while ((n < 3 || hostReady_n !== 1'b0) && n < 400) begin
      @(posedge clk);
      n++;
    end
    q = hostDataOut;
    hostChipSelect <= 1'b1;
    hostDataStrobeOne <= 1'b1;
    hostDataStrobeTwo <= 1'b1;
    useTwo <= ~useTwo;
    // write data held past the strobe rise
    @(posedge clk);
    hostDataIn <= ~d;
    repeat (4) @(posedge clk);
  endtask
  // strobe pins set to a pattern that must not start an access
  task automatic glitch(input logic c, a, b);
    hostChipSelect <= c;
    hostDataStrobeOne <= a;
    hostDataStrobeTwo <= b;
    repeat (8) @(posedge clk);
    hostChipSelect <= 1'b1;
    hostDataStrobeOne <= 1'b1;
    hostDataStrobeTwo <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the host parallel port handshake
// assumes host_model on the pins, bench-side fetch and write buffer
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        sixteenBitHostMode = 1'b0;
  logic        fetchLoaded = 1'b0;
  logic        writeBufferFull = 1'b0;
  logic [31:0] fetchData = 32'h0;
  logic        hostChipSelect, hostDataStrobeOne, hostDataStrobeTwo;
  logic        hostAddressStrobeN, hostReadWriteSelect, halfwordSelect;
  logic        hostDataOe, hostReady_n, fetchRequest, writeStrobe;
  logic [1:0]  hostAccessControl;
  logic [31:0] hostDataIn, hostDataOut, writeData, lastW, rd;
  logic [31:0] seed = 32'h00015530;
  int          failures = 0, n_compared = 0, cycles = 0;
  int          fetches = 0, delay = 0;
  host_port_pkg::select_type accessSelect;

  host_parallel_port_handshake host_parallel_port_handshake_i (
    .clk                 (clk),
    .reset               (reset),
    .sixteenBitHostMode  (sixteenBitHostMode),
    .hostChipSelect      (hostChipSelect),
    .hostDataStrobeOne   (hostDataStrobeOne),
    .hostDataStrobeTwo   (hostDataStrobeTwo),
    .hostAddressStrobeN  (hostAddressStrobeN),
    .hostAccessControl   (hostAccessControl),
    .hostReadWriteSelect (hostReadWriteSelect),
    .halfwordSelect      (halfwordSelect),
    .hostDataIn          (hostDataIn),
    .hostDataOut         (hostDataOut),
    .hostDataOe          (hostDataOe),
    .hostReady_n         (hostReady_n),
    .fetchRequest        (fetchRequest),
    .fetchLoaded         (fetchLoaded),
    .fetchData           (fetchData),
    .writeBufferFull     (writeBufferFull),
    .writeStrobe         (writeStrobe),
    .writeData           (writeData),
    .accessSelect        (accessSelect)
  );
  host_model host_model_i (
    .clk                 (clk),
    .hostReady_n         (hostReady_n),
    .hostDataOut         (hostDataOut),
    .hostChipSelect      (hostChipSelect),
    .hostDataStrobeOne   (hostDataStrobeOne),
    .hostDataStrobeTwo   (hostDataStrobeTwo),
    .hostAddressStrobeN  (hostAddressStrobeN),
    .hostAccessControl   (hostAccessControl),
    .hostReadWriteSelect (hostReadWriteSelect),
    .halfwordSelect      (halfwordSelect),
    .hostDataIn          (hostDataIn)
  );

  always #20 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // fetch side, buffer watch, timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    fetchLoaded <= 1'b0;
    if (fetchRequest === 1'b1) begin
      fetches <= fetches + 1;
      delay <= 2 + int'(seed[2:0]);
    end else if (delay > 0) begin
      chk(32'(hostReady_n), 32'h1);
      delay <= delay - 1;
      fetchLoaded <= (delay == 1);
    end
    if (writeBufferFull === 1'b1) chk(32'(hostReady_n), 32'h1);
    if (hostReady_n === 1'b0) begin
      chk(32'(hostDataOe), 32'(hostReadWriteSelect));
    end
    if (writeStrobe === 1'b1) lastW <= writeData;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      fetchData <= seed;
      host_model_i.access(2'h3, 1'b1, 1'b0, 32'h0, rd);
      chk(rd, seed);
    end
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      writeBufferFull <= seed[0];
      fork
        host_model_i.access(2'h3, 1'b0, 1'b0, seed, rd);
        begin
          repeat (8) @(posedge clk);
          writeBufferFull <= 1'b0;
        end
      join
      chk(lastW, seed);
      chk(32'(accessSelect), 32'hc);
    end
    for (int c = 0; c < 3; c++) begin
      seed = xs(seed);
      host_model_i.access(c[1:0], seed[1], 1'b0, seed, rd);
      chk(32'(accessSelect), 32'({c[1:0], seed[1], 1'b0}));
    end
    chk(32'(fetches), 32'h6);
    sixteenBitHostMode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_model_i.access(2'h3, 1'b1, i[0], 32'h0, rd);
      chk(32'(accessSelect), 32'({2'h3, 1'b1, i[0]}));
    end
    chk(32'(fetches), 32'h8);
    host_model_i.glitch(1'b0, 1'b0, 1'b0);
    host_model_i.glitch(1'b1, 1'b0, 1'b1);
    chk(32'(fetches), 32'h8);
    end_sim();
  end
endmodule
